// ==== hw/scs_ctrl_bank.sv ====
// Purpose: software control bank for system clock and synth output modes
// Assumes: plain strobe port, read data valid one cycle after read strobe
// Notes: unmapped reads return 8'h00, unmapped writes are dropped
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "scs_regs_map.svh"

// Functional notes
// - oscillator register reset 8'h8b, twenty times base
// - bit 2 high selects fast cpu
// - bit 1 enables low voltage reset
// - bit 0 enables high rail, resets off
// - bit 7 picks time-share or summation update
// - bit 6 picks zero or quarter floor
// - synth control register resets to zero
module scs_ctrl_bank (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_stb_in,
	input wire logic rd_stb_in,
	output logic [7:0] rd_data_out,
	output logic [1:0] osc_div_out,
	output logic [5:0] osc_mul_out,
	output logic cpu_fast_out,
	output logic low_voltage_reset_en_out,
	output logic high_rail_out_en_out,
	output scs_pkg::scs_dac_mode_t dac_mode_out,
	output scs_pkg::scs_lvl_mode_t lvl_mode_out,
	output logic [5:0] synth_chan_last_out,
	output logic [6:0] synth_chan_count_out
);
	typedef struct packed {
		logic [7:0] rd_data;
	} scs_bank_t;
	scs_bank_t st_q;
	scs_bank_t st_d;
	logic [7:0] osc_ratio_q;
	logic [7:0] synth_ctrl_q;
	logic [7:0] adv_ctrl_q;
	logic hit_osc;
	logic hit_syn;
	logic hit_adv;

	assign hit_osc = (addr_in == `SCS_OFS_OSC_RATIO);
	assign hit_syn = (addr_in == `SCS_OFS_SYNTH_CTRL);
	assign hit_adv = (addr_in == `SCS_OFS_ADV_CTRL);

	scs_reg8 #(
		.RST_VAL(`SCS_RST_OSC_RATIO),
		.WR_MASK(8'hff)
	) u_osc_ratio (
		.ref_clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.wr_en_in(wr_stb_in && hit_osc),
		.wr_data_in(wr_data_in),
		.val_out(osc_ratio_q)
	);

	scs_reg8 #(
		.RST_VAL(`SCS_RST_SYNTH_CTRL),
		.WR_MASK(8'hff)
	) u_synth_ctrl (
		.ref_clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.wr_en_in(wr_stb_in && hit_syn),
		.wr_data_in(wr_data_in),
		.val_out(synth_ctrl_q)
	);

	// upper three bits masked off on write and reset
	scs_reg8 #(
		.RST_VAL({3'h0, `SCS_RST_ADV_CTRL}),
		.WR_MASK(8'h1f)
	) u_adv_ctrl (
		.ref_clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.wr_en_in(wr_stb_in && hit_adv),
		.wr_data_in(wr_data_in),
		.val_out(adv_ctrl_q)
	);

	always_comb begin
		st_d = st_q;
		st_d.rd_data = 8'h00;
		if (rd_stb_in) begin
			if (hit_osc) begin
				st_d.rd_data = osc_ratio_q;
			end else if (hit_syn) begin
				st_d.rd_data = synth_ctrl_q;
			end else if (hit_adv) begin
				st_d.rd_data = adv_ctrl_q;
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rd_data_out = st_q.rd_data;
	// split ratio into divider and multiplier
	assign osc_div_out = osc_ratio_q[`SCS_OSC_DIV_MSB:`SCS_OSC_DIV_LSB];
	assign osc_mul_out = osc_ratio_q[`SCS_OSC_MUL_MSB:`SCS_OSC_MUL_LSB];
	assign cpu_fast_out = adv_ctrl_q[`SCS_ADV_CPU_FAST];
	assign low_voltage_reset_en_out = adv_ctrl_q[`SCS_ADV_LVR_EN];
	assign high_rail_out_en_out = adv_ctrl_q[`SCS_ADV_HI_RAIL];
	assign dac_mode_out =
		scs_pkg::scs_dac_mode_t'(synth_ctrl_q[`SCS_SYN_DAC_MODE]);
	assign lvl_mode_out =
		scs_pkg::scs_lvl_mode_t'(synth_ctrl_q[`SCS_SYN_LVL_MODE]);
	assign synth_chan_last_out =
		synth_ctrl_q[`SCS_SYN_CHAN_MSB:`SCS_SYN_CHAN_LSB];
	// stored value is count minus one
	assign synth_chan_count_out = {1'b0, synth_chan_last_out} + 7'h01;

	a_osc_reset_val: assert property (@(posedge ref_clk_in)
		$rose(arst_n_in) |-> osc_ratio_q == `SCS_RST_OSC_RATIO)
		else $error("oscillator reset value wrong");
	a_osc_fields: assert property (@(posedge ref_clk_in)
		disable iff (!arst_n_in)
		wr_stb_in && hit_osc |=> {osc_div_out, osc_mul_out} == $past(wr_data_in))
		else $error("oscillator fields not written");
	a_cpu_speed: assert property (@(posedge ref_clk_in)
		disable iff (!arst_n_in)
		wr_stb_in && hit_adv |=> cpu_fast_out == $past(wr_data_in[2]))
		else $error("cpu speed bit wrong");
	a_lvr_enable: assert property (@(posedge ref_clk_in)
		disable iff (!arst_n_in)
		wr_stb_in && hit_adv |=>
			low_voltage_reset_en_out == $past(wr_data_in[1]))
		else $error("low voltage reset bit wrong");
	a_rail_reset: assert property (@(posedge ref_clk_in)
		$rose(arst_n_in) |-> !high_rail_out_en_out && cpu_fast_out
			&& low_voltage_reset_en_out)
		else $error("advanced reset value wrong");
	a_dac_mode: assert property (@(posedge ref_clk_in)
		disable iff (!arst_n_in)
		wr_stb_in && hit_syn |=> dac_mode_out == $past(wr_data_in[7]))
		else $error("dac mode bit wrong");
	a_lvl_mode: assert property (@(posedge ref_clk_in)
		disable iff (!arst_n_in)
		wr_stb_in && hit_syn |=> lvl_mode_out == $past(wr_data_in[6]))
		else $error("level mode bit wrong");
	a_synth_reset: assert property (@(posedge ref_clk_in)
		$rose(arst_n_in) |-> synth_ctrl_q == 8'h00)
		else $error("synth control reset wrong");
	a_adv_reserved: assert property (@(posedge ref_clk_in)
		disable iff (!arst_n_in)
		rd_stb_in && hit_adv |=> rd_data_out[7:5] == 3'h0)
		else $error("reserved bits read nonzero");
	a_read_stable: assert property (@(posedge ref_clk_in)
		disable iff (!arst_n_in)
		!rd_stb_in |=> rd_data_out == 8'h00)
		else $error("read data outside read slot");

	// request shapes shared by the write and read-back checks
	sequence s_wr_osc;
		wr_stb_in && hit_osc;
	endsequence
	sequence s_wr_syn;
		wr_stb_in && hit_syn;
	endsequence
	sequence s_wr_adv;
		wr_stb_in && hit_adv;
	endsequence
	sequence s_rd_osc;
		rd_stb_in && hit_osc;
	endsequence
	sequence s_rd_syn;
		rd_stb_in && hit_syn;
	endsequence
	sequence s_rd_adv;
		rd_stb_in && hit_adv;
	endsequence
	sequence s_rd_none;
		rd_stb_in && !hit_osc && !hit_syn && !hit_adv;
	endsequence

	a_rail_write: assert property (@(posedge ref_clk_in)
		disable iff (!arst_n_in)
		s_wr_adv |=>
			high_rail_out_en_out == $past(wr_data_in[`SCS_ADV_HI_RAIL]))
		else $error("high rail bit wrong");
	a_adv_reset: assert property (@(posedge ref_clk_in)
		$rose(arst_n_in) |-> adv_ctrl_q == {3'h0, `SCS_RST_ADV_CTRL})
		else $error("advanced control reset wrong");
	a_chan_reset: assert property (@(posedge ref_clk_in)
		$rose(arst_n_in) |-> synth_chan_count_out == 7'h01)
		else $error("channel count reset wrong");
	a_chan_last: assert property (@(posedge ref_clk_in)
		disable iff (!arst_n_in)
		s_wr_syn |=> synth_chan_last_out ==
			$past(wr_data_in[`SCS_SYN_CHAN_MSB:`SCS_SYN_CHAN_LSB]))
		else $error("channel field not written");
	a_chan_count: assert property (@(posedge ref_clk_in)
		disable iff (!arst_n_in)
		s_wr_syn |=> synth_chan_count_out ==
			{1'b0, $past(wr_data_in[`SCS_SYN_CHAN_MSB:`SCS_SYN_CHAN_LSB])}
			+ 7'h01)
		else $error("channel count not last plus one");
	a_rd_osc_data: assert property (@(posedge ref_clk_in)
		disable iff (!arst_n_in)
		s_rd_osc |=> rd_data_out == $past(osc_ratio_q))
		else $error("oscillator read-back wrong");
	a_rd_syn_data: assert property (@(posedge ref_clk_in)
		disable iff (!arst_n_in)
		s_rd_syn |=> rd_data_out == $past(synth_ctrl_q))
		else $error("synth control read-back wrong");
	a_rd_adv_data: assert property (@(posedge ref_clk_in)
		disable iff (!arst_n_in)
		s_rd_adv |=> rd_data_out == $past(adv_ctrl_q))
		else $error("advanced control read-back wrong");
	a_rd_unmapped: assert property (@(posedge ref_clk_in)
		disable iff (!arst_n_in)
		s_rd_none |=> rd_data_out == 8'h00)
		else $error("unmapped read not zero");
	a_osc_hold: assert property (@(posedge ref_clk_in)
		disable iff (!arst_n_in)
		!(wr_stb_in && hit_osc) |=> $stable(osc_ratio_q))
		else $error("oscillator register changed without write");
	a_syn_hold: assert property (@(posedge ref_clk_in)
		disable iff (!arst_n_in)
		!(wr_stb_in && hit_syn) |=> $stable(synth_ctrl_q))
		else $error("synth register changed without write");
	a_adv_hold: assert property (@(posedge ref_clk_in)
		disable iff (!arst_n_in)
		!(wr_stb_in && hit_adv) |=> $stable(adv_ctrl_q))
		else $error("advanced register changed without write");
endmodule : scs_ctrl_bank

// ==== hw/scs_regs_map.svh ====
// Purpose: offsets, field positions and reset values of the clock/synth bank
// Assumes: byte-wide registers on a plain 16-bit address port
// Notes: definitions only
`ifndef SCS_REGS_MAP_SVH
`define SCS_REGS_MAP_SVH
`define SCS_OFS_OSC_RATIO 16'h1003
`define SCS_OFS_SYNTH_CTRL 16'h1008
`define SCS_OFS_ADV_CTRL 16'h1020
`define SCS_RST_OSC_RATIO 8'h8b
`define SCS_RST_SYNTH_CTRL 8'h00
`define SCS_RST_ADV_CTRL 5'h0e
`define SCS_OSC_DIV_MSB 7
`define SCS_OSC_DIV_LSB 6
`define SCS_OSC_MUL_MSB 5
`define SCS_OSC_MUL_LSB 0
`define SCS_ADV_CPU_FAST 2
`define SCS_ADV_LVR_EN 1
`define SCS_ADV_HI_RAIL 0
`define SCS_ADV_KEEP_MSB 4
`define SCS_SYN_DAC_MODE 7
`define SCS_SYN_LVL_MODE 6
`define SCS_SYN_CHAN_MSB 5
`define SCS_SYN_CHAN_LSB 0
`define SCS_BASE_CLK_KHZ 1200
`define SCS_RST_MUL_X 20
`endif

// ==== hw/scs_pkg.sv ====
// Purpose: types of the clock/synth control bank
// Assumes: nothing
// Notes: constants live in scs_regs_map.svh
package scs_pkg;
	typedef enum logic {
		SCS_DAC_TIME_SHARE = 1'b0,
		SCS_DAC_SUMMATION = 1'b1
	} scs_dac_mode_t;
	typedef enum logic {
		SCS_LVL_ZERO = 1'b0,
		SCS_LVL_QUARTER = 1'b1
	} scs_lvl_mode_t;
endpackage : scs_pkg

// ==== hw/scs_reg8.sv ====
// Purpose: one byte register with reset value and write enable
// Assumes: single clock, async active-low reset
// Notes: unused bits are masked here, on write and reset, by the caller's WR_MASK
`timescale 1ns/1ps
module scs_reg8 #(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [7:0] WR_MASK = 8'hff
) (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic wr_en_in,
	input wire logic [7:0] wr_data_in,
	output logic [7:0] val_out
);
	typedef struct packed {
		logic [7:0] val;
	} scs_r8_t;
	scs_r8_t st_q;
	scs_r8_t st_d;

	always_comb begin
		st_d = st_q;
		if (wr_en_in) begin
			st_d.val = wr_data_in & WR_MASK;
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st_q <= RST_VAL & WR_MASK;
		end else begin
			st_q <= st_d;
		end
	end

	assign val_out = st_q.val;
endmodule : scs_reg8

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench for the clock/synth control bank
// Assumes: reads answer one cycle after the strobe
// Notes: random data from an lfsr seeded 32'h185c
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, pend = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wd = 8'h00, rdat, v, s, a;
	logic [1:0] div;
	logic [5:0] mul, last;
	logic [6:0] cnt;
	logic fast, lvr, rail;
	scs_pkg::scs_dac_mode_t dac;
	scs_pkg::scs_lvl_mode_t lvl;
	logic [7:0] q[$];
	int failures = 0, tests_run = 0;
	logic [31:0] lf = 32'h185c;
	scs_ctrl_bank i_dut (.ref_clk_in(clk), .arst_n_in(rst_n),
		.addr_in(addr), .wr_data_in(wd), .wr_stb_in(wr), .rd_stb_in(rd),
		.rd_data_out(rdat), .osc_div_out(div), .osc_mul_out(mul),
		.cpu_fast_out(fast), .low_voltage_reset_en_out(lvr),
		.high_rail_out_en_out(rail), .dac_mode_out(dac),
		.lvl_mode_out(lvl), .synth_chan_last_out(last),
		.synth_chan_count_out(cnt));
	initial begin
		forever #10 clk = ~clk;
	end
	function automatic logic [7:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf[7:0];
	endfunction : rnd
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		tests_run++;
		if (g !== e) begin
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
			failures++;
		end
	endtask : chk
	task automatic wrt(input logic [15:0] ad, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= ad;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wrt
	// expectation queued, compared by the monitor below
	task automatic rdq(input logic [15:0] ad, input logic [7:0] e);
		q.push_back(e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= ad;
		@(posedge clk);
		rd <= 1'b0;
	endtask : rdq
	task automatic ctl(input logic [7:0] o, input logic [7:0] y,
		input logic [2:0] c);
		@(negedge clk);
		chk({div, mul, dac, lvl, last, fast, lvr, rail}, {o, y, c});
	endtask : ctl
	task automatic rst_chk();
		ctl(8'h8b, 8'h00, 3'h6);
		chk(cnt, 7'h01);
		rdq(16'h1003, 8'h8b);
		rdq(16'h1008, 8'h00);
		rdq(16'h1020, 8'h0e);
	endtask : rst_chk
	task automatic finish_test();
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	always @(posedge clk) begin
		pend <= rd;
	end
	// read data stands one cycle, zero otherwise
	always @(negedge clk) begin
		if (pend)
			chk(rdat, q.pop_front());
		else
			chk(rdat, 8'h00);
	end
	initial begin
		#100000;
		failures++;
		finish_test();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rst_chk();
		for (int i = 0; i < 24; i++) begin
			v = rnd();
			s = rnd();
			a = rnd();
			wrt(16'h1003, v);
			wrt(16'h1008, s);
			wrt(16'h1020, a);
			wrt(16'h1021, ~v);
			rdq(16'h1003, v);
			rdq(16'h1008, s);
			rdq(16'h1020, {3'h0, a[4:0]});
			rdq(16'h1004, 8'h00);
			ctl(v, s, a[2:0]);
			chk(cnt, s[5:0] + 7'h01);
		end
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		rst_chk();
		repeat (3) @(posedge clk);
		finish_test();
	end
endmodule : tb_top
